// ===== hbfp_pkg.sv
package hbfp_pkg;

    localparam int CLK_PERIOD_NS    = 50;
    localparam int BLANK_TIME_NS    = 11000;
    localparam int TRANS_TIME_NS    = 90000;
    localparam int FILTER_TIME_NS   = 2000;
    localparam int SHUTOFF_TIME_NS  = 1000;
    localparam int PARTNER_DELAY_NS = 500;

    // least times round up, longest times round down
    localparam int BLANK_CYC   = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRANS_CYC   = (TRANS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CYC  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHUTOFF_CYC = SHUTOFF_TIME_NS / CLK_PERIOD_NS;
    localparam int PARTNER_CYC = (PARTNER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 12;

    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_DIAG   = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;

    localparam int CFG_W          = 3;
    localparam int CFG_LIMIT_LO   = 0;
    localparam int CFG_LIMIT_HI   = 1;
    localparam int CFG_SINGLE     = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 3'h2;

    typedef struct packed {
        logic [1:0] hs_above_limit;
        logic [1:0] hs_above_release;
        logic [1:0] hs_above_short;
        logic [1:0] ls_above_short;
        logic [1:0] outx_below_low_ref;
        logic [1:0] outx_above_high_ref;
        logic       over_temp;
        logic       supply_uv;
        logic       vdd_fail;
        logic       vdd_below_por;
        logic       io_supply_pin;
        logic       bridge_enable_n;
        logic       bridge_disable;
        logic       drive_input_one;
        logic       drive_input_two;
    } hbfp_sense_t;

    typedef struct packed {
        logic high_switch_one;
        logic low_switch_one;
        logic high_switch_two;
        logic low_switch_two;
    } hbfp_gate_t;

    typedef struct packed {
        logic       supply_uv_fault;
        logic       over_temp_fault;
        logic [1:0] open_load_fault;
        logic [1:0] short_to_supply_fault;
        logic [1:0] short_to_ground_fault;
    } hbfp_diag_t;

endpackage

// ===== hbfp_fault_protect.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module hbfp_fault_protect #(
    parameter int CNT_W       = hbfp_pkg::CNT_W,
    parameter int BLANK_CYC   = hbfp_pkg::BLANK_CYC,
    parameter int TRANS_CYC   = hbfp_pkg::TRANS_CYC,
    parameter int FILTER_CYC  = hbfp_pkg::FILTER_CYC,
    parameter int PARTNER_CYC = hbfp_pkg::PARTNER_CYC
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire hbfp_pkg::hbfp_sense_t i_sense,
    input  wire logic [3:0]           i_reg_addr,
    input  wire logic [7:0]           i_reg_wdata,
    input  wire logic                 i_reg_wr,
    input  wire logic                 i_reg_rd,
    output var logic [7:0]            o_reg_rdata,
    output var hbfp_pkg::hbfp_gate_t  o_gate,
    output var hbfp_pkg::hbfp_diag_t  o_diag,
    output var logic [1:0]            o_limit_level,
    output var logic                  o_diag_current_en,
    output var logic                  o_fault_flag_n_o,
    output var logic                  o_fault_flag_n_oe
);

    localparam logic [CNT_W-1:0] BLANK_LIM   = CNT_W'(BLANK_CYC);
    localparam logic [CNT_W-1:0] TRANS_LIM   = CNT_W'(TRANS_CYC);
    localparam logic [CNT_W-1:0] FILTER_LIM  = CNT_W'(FILTER_CYC);
    localparam logic [CNT_W-1:0] PARTNER_LIM = CNT_W'(PARTNER_CYC);
    localparam int PD_WAIT = PARTNER_CYC + 3;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        sat_inc = (c == '1) ? c : c + 1'b1;
    endfunction

    hbfp_pkg::hbfp_sense_t meta_r;
    hbfp_pkg::hbfp_sense_t sense_r;
    logic [hbfp_pkg::CFG_W-1:0] cfg_r;
    logic [CNT_W-1:0] gnd_cnt_r [2];
    logic [CNT_W-1:0] sup_cnt_r [2];
    logic [CNT_W-1:0] lim_cnt_r [2];
    logic [CNT_W-1:0] trans_cnt_r;
    logic [CNT_W-1:0] pd_cnt_r;
    logic [1:0]       gnd_fault_r;
    logic [1:0]       sup_fault_r;
    logic [1:0]       chop_r;
    logic             flag_pull_r;
    logic [7:0]       rdata_r;

    logic             flag_mode;
    logic             single_mode;
    logic             pin_off;
    logic             supply_off;
    logic             all_off;
    logic [1:0]       hs_on;
    logic [1:0]       ls_on;
    logic [1:0]       gnd_hit;
    logic [1:0]       sup_hit;
    logic [1:0]       lim_hit;
    logic [1:0]       stage_off;
    logic             any_short;
    logic             partner_off;
    logic [1:0]       out_off;
    logic [1:0]       drive;
    logic [1:0]       chop_want;
    logic             trans_ok;
    logic             diag_en;
    logic             open_bridge;
    logic [1:0]       open_single;
    logic [1:0]       open_nxt;
    logic             flag_pull_nxt;
    logic             wr_cfg;
    logic             wr_diag;
    logic [1:0]       clr_gnd;
    logic [1:0]       clr_sup;
    logic [7:0]       rd_mux;
    hbfp_pkg::hbfp_gate_t gate_nxt;
    hbfp_pkg::hbfp_diag_t diag_nxt;

    // pins are asynchronous to i_clock, two stages before use
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            meta_r  <= '0;
            sense_r <= '0;
        end else begin
            meta_r  <= i_sense;
            sense_r <= meta_r;
        end
    end

    // grounded io supply selects flag mode
    assign flag_mode   = ~sense_r.io_supply_pin;
    assign single_mode = cfg_r[hbfp_pkg::CFG_SINGLE];
    assign pin_off     = sense_r.bridge_enable_n | sense_r.bridge_disable;
    // overheat and undervoltage switch all off
    assign supply_off  = sense_r.supply_uv | sense_r.vdd_fail | sense_r.over_temp
                         | sense_r.vdd_below_por;
    assign all_off     = pin_off | supply_off;

    assign hs_on = {o_gate.high_switch_two, o_gate.high_switch_one};
    assign ls_on = {o_gate.low_switch_two, o_gate.low_switch_one};

    // filter counters run only while the matching switch is on
    always_ff @(posedge i_clock) begin
        for (int k = 0; k < 2; k++) begin
            if (!i_rstn || !hs_on[k] || !sense_r.hs_above_short[k]) begin
                gnd_cnt_r[k] <= '0;
            end else begin
                gnd_cnt_r[k] <= sat_inc(gnd_cnt_r[k]);
            end
            if (!i_rstn || !ls_on[k] || !sense_r.ls_above_short[k]) begin
                sup_cnt_r[k] <= '0;
            end else begin
                sup_cnt_r[k] <= sat_inc(sup_cnt_r[k]);
            end
        end
    end

    // blanking counter only in bridge mode
    always_ff @(posedge i_clock) begin
        for (int k = 0; k < 2; k++) begin
            if (!i_rstn || single_mode || !hs_on[k] || !sense_r.hs_above_limit[k]) begin
                lim_cnt_r[k] <= '0;
            end else begin
                lim_cnt_r[k] <= sat_inc(lim_cnt_r[k]);
            end
        end
    end

    for (genvar k = 0; k < 2; k++) begin : g_hit
        assign gnd_hit[k] = (gnd_cnt_r[k] >= FILTER_LIM);
        assign sup_hit[k] = (sup_cnt_r[k] >= FILTER_LIM);
        assign lim_hit[k] = (lim_cnt_r[k] > BLANK_LIM);
    end

    // software clears latched shorts by writing ones; a new hit wins
    assign wr_cfg  = i_reg_wr && (i_reg_addr == hbfp_pkg::ADDR_CONFIG);
    assign wr_diag = i_reg_wr && (i_reg_addr == hbfp_pkg::ADDR_DIAG);
    assign clr_gnd = wr_diag ? i_reg_wdata[1:0] : 2'h0;
    assign clr_sup = wr_diag ? i_reg_wdata[3:2] : 2'h0;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            gnd_fault_r <= 2'h0;
            sup_fault_r <= 2'h0;
        end else begin
            gnd_fault_r <= gnd_hit | (gnd_fault_r & ~clr_gnd);
            sup_fault_r <= sup_hit | (sup_fault_r & ~clr_sup);
        end
    end

    // affected stage off on the cycle after detection
    assign stage_off = gnd_fault_r | sup_fault_r;
    assign any_short = |stage_off;

    // partner delay only in bridge mode
    always_ff @(posedge i_clock) begin
        if (!i_rstn || !any_short || single_mode) begin
            pd_cnt_r <= '0;
        end else begin
            pd_cnt_r <= sat_inc(pd_cnt_r);
        end
    end
    assign partner_off = (pd_cnt_r >= PARTNER_LIM);

    // hold forcing until current falls under release level
    assign chop_want = single_mode ? 2'h0 : (lim_hit | (chop_r & sense_r.hs_above_release));
    // spacing counter starts full so the first transition is not delayed
    assign trans_ok  = (trans_cnt_r >= TRANS_LIM);

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            chop_r      <= 2'h0;
            trans_cnt_r <= TRANS_LIM;
        end else if (single_mode) begin
            chop_r      <= 2'h0;
            trans_cnt_r <= sat_inc(trans_cnt_r);
        end else if ((chop_want != chop_r) && trans_ok) begin
            chop_r      <= chop_want;
            trans_cnt_r <= '0;
        end else begin
            trans_cnt_r <= sat_inc(trans_cnt_r);
        end
    end

    // overcurrent in one high switch forces the other output high
    assign drive[0] = sense_r.drive_input_one | chop_r[1];
    assign drive[1] = sense_r.drive_input_two | chop_r[0];
    // partner_off never rises in single switch mode
    assign out_off  = {2{all_off | partner_off}} | stage_off;

    assign gate_nxt.high_switch_one = drive[0] & ~out_off[0];
    assign gate_nxt.low_switch_one  = ~drive[0] & ~out_off[0];
    assign gate_nxt.high_switch_two = drive[1] & ~out_off[1];
    assign gate_nxt.low_switch_two  = ~drive[1] & ~out_off[1];

    // sources only when pins disable, no short latched, not flag mode
    assign diag_en     = pin_off & ~any_short & ~flag_mode;
    // only out one high and out two low is open
    assign open_bridge = ~sense_r.outx_below_low_ref[0] & sense_r.outx_below_low_ref[1];
    assign open_single = ~sense_r.outx_below_low_ref & ~sense_r.outx_above_high_ref;
    assign open_nxt    = !diag_en ? 2'h0 : (single_mode ? open_single : {1'b0, open_bridge});

    assign diag_nxt.supply_uv_fault       = sense_r.supply_uv;
    assign diag_nxt.over_temp_fault       = sense_r.over_temp;
    assign diag_nxt.open_load_fault       = open_nxt;
    assign diag_nxt.short_to_supply_fault = sup_fault_r;
    assign diag_nxt.short_to_ground_fault = gnd_fault_r;

    // flag pulled low only in flag mode with logic supply valid
    assign flag_pull_nxt = flag_mode & ~sense_r.vdd_below_por
                           & (sense_r.supply_uv | pin_off | sense_r.vdd_fail
                              | any_short | sense_r.over_temp);

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_gate            <= '0;
            o_diag            <= '0;
            o_diag_current_en <= 1'b0;
            flag_pull_r       <= 1'b0;
        end else begin
            o_gate            <= gate_nxt;
            o_diag            <= diag_nxt;
            o_diag_current_en <= diag_en;
            flag_pull_r       <= flag_pull_nxt;
        end
    end

    // open drain: only ever drives low
    assign o_fault_flag_n_o  = 1'b0;
    assign o_fault_flag_n_oe = flag_pull_r;

    // limit level straight from two configuration bits
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cfg_r <= hbfp_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= i_reg_wdata[hbfp_pkg::CFG_W-1:0];
        end
    end
    assign o_limit_level = {cfg_r[hbfp_pkg::CFG_LIMIT_HI], cfg_r[hbfp_pkg::CFG_LIMIT_LO]};

    assign rd_mux = (i_reg_addr == hbfp_pkg::ADDR_CONFIG) ? {5'h00, cfg_r} :
                    (i_reg_addr == hbfp_pkg::ADDR_DIAG)   ? o_diag :
                    (i_reg_addr == hbfp_pkg::ADDR_STATUS) ?
                        {4'h0, flag_mode, all_off, chop_r} : 8'h00;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (!i_rstn || !i_reg_rd) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_mux;
        end
    end
    assign o_reg_rdata = rdata_r;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    property p_flag_uv;
        (flag_mode && sense_r.supply_uv && !sense_r.vdd_below_por) |=> o_fault_flag_n_oe;
    endproperty
    a_flag_uv: assert property (p_flag_uv) else $error("flag not pulled on undervoltage");

    property p_flag_por;
        sense_r.vdd_below_por |=> !o_fault_flag_n_oe;
    endproperty
    a_flag_por: assert property (p_flag_por) else $error("flag pulled below por");

    property p_overheat_off;
        sense_r.over_temp |=> (o_gate == '0) && o_diag.over_temp_fault;
    endproperty
    a_overheat_off: assert property (p_overheat_off) else $error("gates on in overheat");

    property p_uv_off;
        sense_r.supply_uv |=> (o_gate == '0);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("gates on in undervoltage");

    property p_short_stage_off;
        stage_off[0] |=> !o_gate.high_switch_one && !o_gate.low_switch_one;
    endproperty
    a_short_stage_off: assert property (p_short_stage_off) else $error("shorted stage on");

    property p_partner_off;
        ($rose(any_short) && !single_mode) ##1 (any_short && !single_mode) [*3]
            |-> ##[1:PD_WAIT] (o_gate == '0);
    endproperty
    a_partner_off: assert property (p_partner_off) else $error("partner stage not off");

    property p_single_no_chop;
        single_mode |=> (chop_r == 2'h0);
    endproperty
    a_single_no_chop: assert property (p_single_no_chop) else $error("chop in single mode");

    property p_chop_spacing;
        (chop_r != $past(chop_r)) && !$past(single_mode) |-> $past(trans_ok);
    endproperty
    a_chop_spacing: assert property (p_chop_spacing) else $error("chop transition too soon");

    property p_chop_force;
        (chop_r[0] && !all_off && !(|stage_off) && !partner_off) |=> o_gate.high_switch_two;
    endproperty
    a_chop_force: assert property (p_chop_force) else $error("opposite output not forced");

    property p_diag_sources;
        o_diag_current_en |-> !$past(flag_mode) && !$past(any_short) && $past(pin_off);
    endproperty
    a_diag_sources: assert property (p_diag_sources) else $error("sources on wrongly");

    property p_open_bridge;
        (diag_en && !single_mode && open_bridge) |=> o_diag.open_load_fault[0];
    endproperty
    a_open_bridge: assert property (p_open_bridge) else $error("bridge open load missed");

    property p_flag_short;
        (flag_mode && any_short && !sense_r.vdd_below_por) |=> o_fault_flag_n_oe;
    endproperty
    a_flag_short: assert property (p_flag_short) else $error("flag not pulled on short");

    property p_flag_pins;
        (flag_mode && pin_off && !sense_r.vdd_below_por) |=> o_fault_flag_n_oe;
    endproperty
    a_flag_pins: assert property (p_flag_pins) else $error("flag not pulled on disable");

    property p_flag_idle;
        !flag_mode |=> !o_fault_flag_n_oe;
    endproperty
    a_flag_idle: assert property (p_flag_idle) else $error("flag pulled outside flag mode");

    property p_gnd_gate;
        (gnd_cnt_r[0] != '0) |-> $past(hs_on[0]) && $past(sense_r.hs_above_short[0]);
    endproperty
    a_gnd_gate: assert property (p_gnd_gate) else $error("ground filter ran, high off");

    property p_sup_gate;
        (sup_cnt_r[0] != '0) |-> $past(ls_on[0]) && $past(sense_r.ls_above_short[0]);
    endproperty
    a_sup_gate: assert property (p_sup_gate) else $error("supply filter ran, low off");

    property p_gnd_filter;
        $rose(gnd_fault_r[0]) |-> ($past(gnd_cnt_r[0]) >= FILTER_LIM);
    endproperty
    a_gnd_filter: assert property (p_gnd_filter) else $error("ground short too early");

    property p_sup_filter;
        $rose(sup_fault_r[1]) |-> ($past(sup_cnt_r[1]) >= FILTER_LIM);
    endproperty
    a_sup_filter: assert property (p_sup_filter) else $error("supply short too early");

    property p_stage_sup;
        stage_off[1] |=> !o_gate.high_switch_two && !o_gate.low_switch_two;
    endproperty
    a_stage_sup: assert property (p_stage_sup) else $error("shorted stage two on");

    property p_single_keep;
        (single_mode && $past(single_mode) && !stage_off[1] && !all_off)
            |=> (o_gate.high_switch_two || o_gate.low_switch_two);
    endproperty
    a_single_keep: assert property (p_single_keep) else $error("healthy output stopped");

    property p_chop_release;
        (chop_r[0] && !sense_r.hs_above_release[0] && !lim_hit[0] && trans_ok) |=> !chop_r[0];
    endproperty
    a_chop_release: assert property (p_chop_release) else $error("forcing not released");

    property p_open_single;
        (diag_en && single_mode && !sense_r.outx_below_low_ref[1]
            && !sense_r.outx_above_high_ref[1]) |=> o_diag.open_load_fault[1];
    endproperty
    a_open_single: assert property (p_open_single) else $error("single open load missed");

    property p_open_quiet;
        !diag_en |=> (o_diag.open_load_fault == 2'h0);
    endproperty
    a_open_quiet: assert property (p_open_quiet) else $error("open load with sources off");

endmodule

`default_nettype wire

// ===== hbfp_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module hbfp_power_stage (
    input  wire hbfp_pkg::hbfp_sense_t i_base,
    input  wire hbfp_pkg::hbfp_gate_t  i_gate,
    input  wire logic [1:0]            i_gnd_short,
    input  wire logic [1:0]            i_sup_short,
    input  wire logic [1:0]            i_overload,
    output var hbfp_pkg::hbfp_sense_t  o_sense
);
    // current only flows while its switch conducts, so a shutoff ends the fault current
    wire logic [1:0] hs_on = {i_gate.high_switch_two, i_gate.high_switch_one};
    wire logic [1:0] ls_on = {i_gate.low_switch_two, i_gate.low_switch_one};
    always_comb begin
        o_sense = i_base;
        o_sense.hs_above_short = i_base.hs_above_short | (i_gnd_short & hs_on);
        o_sense.ls_above_short = i_base.ls_above_short | (i_sup_short & ls_on);
        o_sense.hs_above_limit = i_base.hs_above_limit | (i_overload & hs_on);
        o_sense.hs_above_release = i_base.hs_above_release | (i_overload & hs_on);
    end
endmodule
`default_nettype wire

// ===== hbfp_fault_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hbfp_fault_protect_tb;
    localparam int BLK = 8;
    localparam int TRN = 16;
    localparam int FLT = 4;
    localparam int PRT = 3;
    localparam int SHT = 2 + FLT + 2 + hbfp_pkg::SHUTOFF_CYC;
    logic                  clk = 1'b0;
    logic                  rstn = 1'b0;
    hbfp_pkg::hbfp_sense_t base;
    hbfp_pkg::hbfp_sense_t sense;
    hbfp_pkg::hbfp_gate_t  gate;
    hbfp_pkg::hbfp_diag_t  diag;
    logic [3:0]            addr = 4'h0;
    logic [7:0]            wdata = 8'h00;
    logic                  wr = 1'b0;
    logic                  rd = 1'b0;
    logic [1:0]            gnd = 2'h0;
    logic [1:0]            sup = 2'h0;
    logic [1:0]            ovl = 2'h0;
    logic [7:0]            rdata;
    logic [7:0]            rv;
    logic [1:0]            level;
    logic                  cur_en;
    logic                  flag_o;
    logic                  flag_oe;
    int                    fails = 0;
    int                    compares = 0;

    hbfp_fault_protect #(.BLANK_CYC(BLK), .TRANS_CYC(TRN), .FILTER_CYC(FLT),
        .PARTNER_CYC(PRT)) uut (.i_clock(clk), .i_rstn(rstn), .i_sense(sense),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_gate(gate), .o_diag(diag), .o_limit_level(level),
        .o_diag_current_en(cur_en), .o_fault_flag_n_o(flag_o),
        .o_fault_flag_n_oe(flag_oe));
    hbfp_power_stage stage (.i_base(base), .i_gate(gate), .i_gnd_short(gnd),
        .i_sup_short(sup), .i_overload(ovl), .o_sense(sense));

    always #25 clk = ~clk;

    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic drive(input logic one, input logic two);
        @(posedge clk);
        base.drive_input_one <= one;
        base.drive_input_two <= two;
        tick(4);
    endtask
    task automatic t_regs;
        check("level_rst", {6'h0, level}, 8'h02);
        reg_wr(4'hF, 8'h07);
        reg_rd(4'h0);
        check("cfg", rv, 8'h02);
        reg_rd(4'hF);
        check("unmapped", rv, 8'h00);
        for (int i = 0; i < 4; i++) begin
            reg_wr(4'h0, 8'(i));
            tick(1);
            check("level", {6'h0, level}, 8'(i));
        end
        reg_wr(4'h0, 8'h02);
    endtask
    task automatic t_shorts;
        drive(1'b1, 1'b0);
        @(posedge clk) base.hs_above_short <= 2'b01;
        repeat (FLT - 1) @(posedge clk);
        base.hs_above_short <= 2'b10;
        tick(FLT + 8);
        check("gnd_off", diag, 8'h00);
        check("glitch", {6'h0, diag.short_to_ground_fault}, 8'h00);
        @(posedge clk) base.hs_above_short <= 2'b00;
        gnd <= 2'b01;
        tick(SHT);
        check("gnd", diag, 8'h01);
        check("hs1", {7'h0, gate.high_switch_one}, 8'h00);
        tick(PRT + 3);
        check("gates", {4'h0, gate}, 8'h00);
        gnd <= 2'b00;
        reg_wr(4'h1, 8'h03);
        tick(4);
        check("clr", diag, 8'h00);
        @(posedge clk) gnd <= 2'b01;
        sup <= 2'b10;
        tick(SHT + PRT + 3);
        check("across", diag, 8'h09);
        check("across_g", {4'h0, gate}, 8'h00);
        gnd <= 2'b00;
        sup <= 2'b00;
        reg_wr(4'h1, 8'h0F);
        reg_wr(4'h0, 8'h06);
        drive(1'b0, 1'b1);
        @(posedge clk) sup <= 2'b01;
        ovl <= 2'b10;
        tick(SHT + BLK + PRT + 3);
        check("sup", diag, 8'h04);
        check("ls1", {7'h0, gate.low_switch_one}, 8'h00);
        check("hs2", {7'h0, gate.high_switch_two}, 8'h01);
        reg_rd(4'h2);
        check("nochop", rv, 8'h00);
        sup <= 2'b00;
        ovl <= 2'b00;
        reg_wr(4'h1, 8'h0F);
        reg_wr(4'h0, 8'h02);
    endtask
    task automatic t_chop;
        drive(1'b1, 1'b0);
        @(posedge clk) ovl <= 2'b01;
        tick(2 + BLK + 4);
        check("force", {7'h0, gate.high_switch_two}, 8'h01);
        @(posedge clk) ovl <= 2'b00;
        tick(5);
        check("spacing", {7'h0, gate.high_switch_two}, 8'h01);
        tick(TRN);
        check("release", {6'h0, gate.high_switch_two, gate.low_switch_two}, 8'h01);
    endtask
    task automatic t_supply;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) base.over_temp <= (k == 0);
            base.supply_uv <= (k == 1);
            tick(4);
            check("off", {4'h0, gate}, 8'h00);
            check("live", {6'h0, diag.supply_uv_fault, diag.over_temp_fault},
                  8'(k + 1));
            @(posedge clk) base.over_temp <= 1'b0;
            base.supply_uv <= 1'b0;
            tick(4);
            check("resume", {7'h0, gate.high_switch_one}, 8'h01);
        end
    endtask
    task automatic cause(input int i, input logic v);
        @(posedge clk);
        case (i)
            0: base.supply_uv <= v;
            1: base.bridge_disable <= v;
            2: base.bridge_enable_n <= v;
            3: base.vdd_fail <= v;
            default: base.over_temp <= v;
        endcase
        tick(4);
    endtask
    task automatic t_flag;
        @(posedge clk) base.io_supply_pin <= 1'b0;
        @(posedge clk) gnd <= 2'b01;
        tick(SHT);
        check("flag_sc", {7'h0, flag_oe}, 8'h01);
        gnd <= 2'b00;
        reg_wr(4'h1, 8'h03);
        tick(4);
        for (int i = 0; i < 5; i++) begin
            cause(i, 1'b1);
            check("flag", {6'h0, flag_oe, flag_o}, 8'h02);
            cause(i, 1'b0);
            check("flag_idle", {7'h0, flag_oe}, 8'h00);
        end
        cause(1, 1'b1);
        check("src_flag", {7'h0, cur_en}, 8'h00);
        @(posedge clk) base.vdd_below_por <= 1'b1;
        tick(4);
        check("por", {7'h0, flag_oe}, 8'h00);
        @(posedge clk) base.vdd_below_por <= 1'b0;
        base.io_supply_pin <= 1'b1;
        tick(4);
    endtask
    task automatic t_open;
        logic [3:0] tab [3] = '{4'b0001, 4'b0100, 4'b0000};
        for (int v = 0; v < 4; v++) begin
            @(posedge clk) base.outx_below_low_ref <= 2'(v);
            tick(4);
            check("ol_br", {6'h0, diag.open_load_fault}, {7'h0, v == 2});
            check("src_on", {7'h0, cur_en}, 8'h01);
        end
        reg_wr(4'h0, 8'h06);
        for (int j = 0; j < 3; j++) begin
            @(posedge clk) {base.outx_above_high_ref, base.outx_below_low_ref} <= tab[j];
            tick(4);
            check("ol_ss", {6'h0, diag.open_load_fault}, j == 2 ? 8'h03 : 8'h02);
        end
        @(posedge clk) base.over_temp <= 1'b1;
        tick(4);
        check("ot_idle", {7'h0, diag.over_temp_fault}, 8'h01);
        @(posedge clk) base.over_temp <= 1'b0;
        base.bridge_disable <= 1'b0;
        tick(4);
        check("src_off", {7'h0, cur_en}, 8'h00);
    endtask
    task automatic wrap_up;
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        base = '0;
        base.io_supply_pin = 1'b1;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        tick(3);
        t_regs();
        t_shorts();
        t_chop();
        t_supply();
        t_flag();
        t_open();
        wrap_up();
    end
    // the whole sequence needs well under two thousand cycles
    initial begin
        #(50 * 20000);
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
